// ### hdl/mdp_gate.sv
// Dual-latch modulator, current limit and fault gating of a three-phase bridge driver.
//
// Implementation choices: the register offsets and strobed register access.
module mdp_gate (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       ramp_start,
  input  wire logic                       ramp_above_cmd,
  input  wire logic                       over_current,
  input  wire logic [2:0]                 uv_trip,
  input  wire logic [2:0]                 uv_release,
  input  wire logic                       thermal_shdn,
  input  wire logic                       output_enable,
  input  wire logic                       brake,
  input  wire logic                       sensor_valid,
  input  wire logic [2:0]                 top_cmd,
  input  wire logic [2:0]                 bottom_cmd,
  input  wire logic [2:0]                 top_drive_i,
  input  wire logic                       fault_i,
  output logic      [2:0]                 top_drive_o,
  output logic      [2:0]                 top_drive_oe_n,
  output logic      [2:0]                 bottom_drive,
  output logic                            fault_o,
  output logic                            fault_oe_n,
  output logic                            irq,
  input  wire logic [mdp_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [mdp_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [mdp_pkg::DATA_W-1:0] reg_rdata
);

  localparam int unsigned SYNC_W = 23;

  function automatic logic hit(input logic [mdp_pkg::ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Synchronised pins.
  wire  [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] s_in;
  wire               s_start;
  wire               s_above;
  wire               s_oc;
  wire  [2:0]        s_trip;
  wire  [2:0]        s_rel;
  wire               s_therm;
  wire               s_en;
  wire               s_brake;
  wire               s_valid;
  wire  [2:0]        s_top;
  wire  [2:0]        s_bot;
  wire  [2:0]        s_top_pin;
  wire               s_fault_pin;

  assign raw_in = {fault_i, top_drive_i, bottom_cmd, top_cmd, sensor_valid, brake,
                   output_enable, thermal_shdn, uv_release, uv_trip, over_current,
                   ramp_above_cmd, ramp_start};

  mdp_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (raw_in),
    .sync_out (s_in)
  );

  assign s_start     = s_in[0];
  assign s_above     = s_in[1];
  assign s_oc        = s_in[2];
  assign s_trip      = s_in[5:3];
  assign s_rel       = s_in[8:6];
  assign s_therm     = s_in[9];
  assign s_en        = s_in[10];
  assign s_brake     = s_in[11];
  assign s_valid     = s_in[12];
  assign s_top       = s_in[15:13];
  assign s_bot       = s_in[18:16];
  assign s_top_pin   = s_in[21:19];
  assign s_fault_pin = s_in[22];

  logic [2:0] uv_q;
  wire        uv_any;

  mdp_hyst #(
    .N (mdp_pkg::UV_CHANS)
  ) u_hyst (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .trip       (s_trip),
    .release_ok (s_rel),
    .active     (uv_q)
  );

  assign uv_any = |uv_q;

  // Latches and cycle edge.
  logic start_prev_q;
  logic pwm_q;
  logic pwm_d;
  logic sense_q;
  logic sense_d;
  wire  start_edge;
  wire  conduct;

  assign start_edge = s_start & ~start_prev_q;
  assign conduct    = pwm_q & sense_q;

  assign pwm_d = start_edge ? 1'b1 : (s_above ? 1'b0 : pwm_q);

  // over-current clears sense
  // Clear beats set so a current still above threshold at cycle start gives no pulse.
  assign sense_d = s_oc ? 1'b0 : (start_edge ? 1'b1 : sense_q);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_prev_q <= 1'b0;
      pwm_q        <= 1'b0;
      sense_q      <= 1'b0;
    end else begin
      start_prev_q <= s_start;
      pwm_q        <= pwm_d;
      sense_q      <= sense_d;
    end
  end

  // Software registers.
  logic                        ctrl_en_q;
  logic [mdp_pkg::EV_W-1:0]    mask_q;
  logic [mdp_pkg::EV_W-1:0]    stat_q;
  logic [mdp_pkg::EV_W-1:0]    stat_d;
  wire  [mdp_pkg::EV_W-1:0]    events;
  logic [mdp_pkg::OCCNT_W-1:0] occnt_q;
  logic [mdp_pkg::OCCNT_W-1:0] occnt_d;
  wire                         en_eff;
  wire                         wr_ctrl;
  wire                         wr_mask;
  wire                         wr_occnt;
  wire                         rd_stat;
  wire                         oc_cut;

  assign wr_ctrl  = reg_wr & hit(reg_addr, mdp_pkg::REG_CTRL);
  assign wr_mask  = reg_wr & hit(reg_addr, mdp_pkg::REG_MASK);
  assign wr_occnt = reg_wr & hit(reg_addr, mdp_pkg::REG_OCCNT);
  assign rd_stat  = reg_rd & hit(reg_addr, mdp_pkg::REG_STAT);

  assign en_eff = s_en & ctrl_en_q & ~s_therm;

  assign oc_cut = sense_q & s_oc;

  assign events[mdp_pkg::EV_OC]      = s_oc;
  assign events[mdp_pkg::EV_UV]      = uv_any;
  assign events[mdp_pkg::EV_THERM]   = s_therm;
  assign events[mdp_pkg::EV_INVALID] = ~s_valid;
  assign events[mdp_pkg::EV_CYCLE]   = start_edge;

  // A read clears the bits it returned, but an event in that cycle survives.
  assign stat_d  = (rd_stat ? '0 : stat_q) | events;
  assign occnt_d = wr_occnt ? '0 :
                   ((oc_cut && occnt_q != '1) ? occnt_q + 1'b1 : occnt_q);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_en_q <= mdp_pkg::CTRL_EN_RST;
      mask_q    <= mdp_pkg::MASK_RST;
      stat_q    <= mdp_pkg::STAT_RST;
      occnt_q   <= '0;
    end else begin
      ctrl_en_q <= wr_ctrl ? reg_wdata[mdp_pkg::CTRL_EN_BIT] : ctrl_en_q;
      mask_q    <= wr_mask ? reg_wdata[mdp_pkg::EV_W-1:0] : mask_q;
      stat_q    <= stat_d;
      occnt_q   <= occnt_d;
    end
  end

  // Drive mode selection.
  mdp_pkg::mdp_mode_t mode;
  logic [2:0]         top_on;
  logic [2:0]         bot_on;
  wire                fault_d;

  always_comb begin
    if (uv_any) begin
      mode = mdp_pkg::MDP_UVLO;
    end else if (s_brake) begin
      mode = mdp_pkg::MDP_BRAKE;
    end else if (!s_valid || !en_eff) begin
      mode = mdp_pkg::MDP_OFF;
    end else begin
      mode = mdp_pkg::MDP_RUN;
    end
  end

  always_comb begin
    case (mode)
      mdp_pkg::MDP_RUN: begin
        top_on = s_top & {3{sense_q}};
        bot_on = s_bot & {3{conduct}};
      end
      mdp_pkg::MDP_BRAKE: begin
        top_on = 3'h0;
        bot_on = 3'h7;
      end
      mdp_pkg::MDP_OFF: begin
        top_on = 3'h0;
        bot_on = 3'h0;
      end
      default: begin
        top_on = 3'h0;
        bot_on = 3'h0;
      end
    endcase
  end

  assign fault_d = uv_any | ~s_valid | ~en_eff | s_oc;

  // Output and bus registers.
  logic [2:0]                 top_oe_n_q;
  logic [2:0]                 bot_q;
  logic                       fault_oe_n_q;
  logic                       pin_low_q;
  logic                       irq_q;
  logic [mdp_pkg::DATA_W-1:0] rdata_q;
  wire  [mdp_pkg::DATA_W-1:0] rdata_d;
  wire  [mdp_pkg::DATA_W-1:0] state_word;

  assign state_word = {20'h00000, s_fault_pin, s_top_pin, mode, fault_d, uv_q,
                       sense_q, pwm_q};

  assign rdata_d = !reg_rd ? 32'h00000000 :
                   hit(reg_addr, mdp_pkg::REG_CTRL)  ? {31'h00000000, ctrl_en_q} :
                   hit(reg_addr, mdp_pkg::REG_STAT)  ? {27'h0000000, stat_q} :
                   hit(reg_addr, mdp_pkg::REG_MASK)  ? {27'h0000000, mask_q} :
                   hit(reg_addr, mdp_pkg::REG_STATE) ? state_word :
                   hit(reg_addr, mdp_pkg::REG_OCCNT) ? {16'h0000, occnt_q} :
                   32'h00000000;

  // open-drain pins pull low when asserted
  // fault may feed enable back externally
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      top_oe_n_q   <= 3'h7;
      bot_q        <= 3'h0;
      fault_oe_n_q <= 1'b0;
      pin_low_q    <= 1'b0;
      irq_q        <= 1'b0;
      rdata_q      <= 32'h00000000;
    end else begin
      top_oe_n_q   <= ~top_on;
      bot_q        <= bot_on;
      fault_oe_n_q <= ~fault_d;
      pin_low_q    <= 1'b0;
      irq_q        <= |(stat_d & mask_q);
      rdata_q      <= rdata_d;
    end
  end

  assign top_drive_o    = {3{pin_low_q}};
  assign top_drive_oe_n = top_oe_n_q;
  assign bottom_drive   = bot_q;
  assign fault_o        = pin_low_q;
  assign fault_oe_n     = fault_oe_n_q;
  assign irq            = irq_q;
  assign reg_rdata      = rdata_q;

  // Checks.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_cycle_sets: assert property (
    start_edge && !s_oc |=> pwm_q && sense_q)
    else $error("Cycle start did not set both latches.");

  chk_ramp_clear: assert property (
    s_above && !start_edge |=> !pwm_q ##1 bot_q == 3'h0 || $past(mode) != mdp_pkg::MDP_RUN)
    else $error("Ramp crossing did not end bottom conduction.");

  chk_top_unchopped: assert property (
    mode == mdp_pkg::MDP_RUN && sense_q && !pwm_q |=>
      top_oe_n_q == ~$past(s_top) && bot_q == 3'h0)
    else $error("Top drive chopped or bottom drive not chopped.");

  chk_sense_clear: assert property (
    s_oc |=> !sense_q ##1
      (top_oe_n_q == 3'h7 && (bot_q == 3'h0 || $past(mode) == mdp_pkg::MDP_BRAKE)))
    else $error("Over-current did not stop conduction.");

  chk_one_pulse: assert property (
    !conduct && !start_edge |=> !conduct)
    else $error("Conduction restarted within one cycle.");

  chk_oc_fault: assert property (
    s_oc |=> !fault_oe_n_q)
    else $error("Over-current did not assert fault.");

  chk_uv_force: assert property (
    uv_any |=> top_oe_n_q == 3'h7 && bot_q == 3'h0 && !fault_oe_n_q)
    else $error("Undervoltage did not force the safe state.");

  chk_uv_hold: assert property (
    uv_q[0] && !s_rel[0] |=> uv_q[0])
    else $error("Undervoltage released without release level.");

  chk_fault_merge: assert property (
    !s_valid || !s_en || s_therm |=> !fault_oe_n_q)
    else $error("Fault source did not pull fault low.");

  chk_therm_brake: assert property (
    s_therm && s_brake && !uv_any |=>
      top_oe_n_q == 3'h7 && bot_q == 3'h7 && !fault_oe_n_q)
    else $error("Thermal shutdown differs from disable.");

  chk_invalid_off: assert property (
    !s_valid && !s_brake && !uv_any |=>
      top_oe_n_q == 3'h7 && bot_q == 3'h0 && !fault_oe_n_q)
    else $error("Invalid sensors left a drive on.");

  chk_brake_clean: assert property (
    s_brake && s_valid && en_eff && !uv_any && !s_oc |=> bot_q == 3'h7 && fault_oe_n_q)
    else $error("Clean brake state wrong.");

  chk_sync_edge: assert property (
    start_edge |=> !start_edge)
    else $error("One cycle start gave two edges.");

  chk_irq_level: assert property (
    (|(stat_q & mask_q)) && !rd_stat |=> irq_q)
    else $error("Unmasked status bit did not raise interrupt.");

endmodule

// ### hdl/mdp_hyst.sv
// Undervoltage indications held between separate trip and release comparators.
module mdp_hyst #(
  parameter int unsigned N = 3
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [N-1:0] trip,
  input  wire logic [N-1:0] release_ok,
  output logic      [N-1:0] active
);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_ch
      // set at trip, clear only at release
      // Starting in lockout keeps the bridge off until each supply proves good.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          active[i] <= mdp_pkg::UV_RST;
        end else if (trip[i]) begin
          active[i] <= 1'b1;
        end else if (release_ok[i]) begin
          active[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// ### hdl/mdp_pkg.sv
// Constants, register map and drive modes of the motor drive gating block.
package mdp_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h04;
  localparam logic [7:0] REG_MASK  = 8'h08;
  localparam logic [7:0] REG_STATE = 8'h0C;
  localparam logic [7:0] REG_OCCNT = 8'h10;

  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic        CTRL_EN_RST = 1'h1;

  localparam int unsigned EV_W       = 5;
  localparam int unsigned EV_OC      = 0;
  localparam int unsigned EV_UV      = 1;
  localparam int unsigned EV_THERM   = 2;
  localparam int unsigned EV_INVALID = 3;
  localparam int unsigned EV_CYCLE   = 4;
  localparam logic [4:0]  MASK_RST   = 5'h00;
  localparam logic [4:0]  STAT_RST   = 5'h00;

  localparam int unsigned ST_PWM   = 0;
  localparam int unsigned ST_SENSE = 1;
  localparam int unsigned ST_UV    = 2;
  localparam int unsigned ST_FAULT = 5;
  localparam int unsigned ST_MODE  = 6;
  localparam int unsigned ST_TOPIN = 8;
  localparam int unsigned ST_FPIN  = 11;

  localparam int unsigned OCCNT_W   = 16;
  localparam int unsigned PHASES    = 3;
  localparam int unsigned UV_CHANS  = 3;
  localparam logic        UV_RST    = 1'h1;

  typedef enum logic [1:0] {
    MDP_RUN,
    MDP_BRAKE,
    MDP_OFF,
    MDP_UVLO
  } mdp_mode_t;

endpackage

// ### hdl/mdp_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels.
module mdp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ### tb/mdp_bridge.sv
// Power bridge, sense resistor and shutdown delay network at the far side of the gating block.
module mdp_bridge #(
  parameter int unsigned DLY = 16
) (
  input  wire logic       clk,
  input  wire logic [2:0] top_drive_o,
  input  wire logic [2:0] top_drive_oe_n,
  input  wire logic [2:0] bottom_drive,
  input  wire logic       fault_o,
  input  wire logic       fault_oe_n,
  input  wire logic       short_cmd,
  input  wire logic       enable_cmd,
  input  wire logic       discharge,
  output logic      [2:0] top_drive_i,
  output logic            fault_i,
  output logic            over_current,
  output logic            output_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] shutdown_delay_capacitor_q;
  // pulled-up wires.
  // A released open-drain pin rests high through its pull-up.
  assign top_drive_i = top_drive_oe_n | top_drive_o;
  assign fault_i     = fault_oe_n | fault_o;
  // sensed winding current.
  // A shorted winding only draws current while some bottom switch conducts.
  assign over_current = short_cmd & (|bottom_drive);
  // delayed latched shutdown.
  // The capacitor charges while fault is low, so a low enable keeps itself low.
  always_ff @(posedge clk) begin
    if (discharge) begin
      shutdown_delay_capacitor_q <= 8'h00;
    end else if (!fault_i && shutdown_delay_capacitor_q != 8'hFF) begin
      shutdown_delay_capacitor_q <= shutdown_delay_capacitor_q + 8'h01;
    end
  end
  assign output_enable = enable_cmd & (shutdown_delay_capacitor_q < DLY[7:0]);
endmodule

// ### tb/testbench.sv
// Self-checking bench of the motor drive gating block with its bridge model.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SET = 6;
  localparam int STEP = 8;
  typedef struct {logic [31:0] exp; logic [31:0] msk; bit pin;} mdp_note_t;
  mdp_note_t   notes[$];
  mdp_note_t   note;
  logic [31:0] seen;
  logic [15:0] on_cnt;
  logic        clk, sys_rst, ramp_start, ramp_above_cmd, over_current, thermal_shdn;
  logic        output_enable, brake, sensor_valid, fault_i, fault_o, fault_oe_n, irq;
  logic        reg_wr, reg_rd, rd_seen, pin_req, short_cmd, enable_cmd, discharge;
  logic [2:0]  uv_trip, uv_release, top_cmd, bottom_cmd, top_drive_i, top_drive_o;
  logic [2:0]  top_drive_oe_n, bottom_drive;
  logic [mdp_pkg::ADDR_W-1:0] reg_addr;
  logic [mdp_pkg::DATA_W-1:0] reg_wdata, reg_rdata;
  logic [11:0] modes [7] = '{12'hE7F, 12'hC7E, 12'hA7E, 12'h270, 12'h470, 12'h770, 12'hF7E};
  int          errors, checks_done, cycles, p, q;
  int          seed = 32'hA4C744AD;

  mdp_gate dut (.clk(clk), .sys_rst(sys_rst), .ramp_start(ramp_start),
    .ramp_above_cmd(ramp_above_cmd), .over_current(over_current), .uv_trip(uv_trip),
    .uv_release(uv_release), .thermal_shdn(thermal_shdn), .output_enable(output_enable),
    .brake(brake), .sensor_valid(sensor_valid), .top_cmd(top_cmd), .bottom_cmd(bottom_cmd),
    .top_drive_i(top_drive_i), .fault_i(fault_i), .top_drive_o(top_drive_o),
    .top_drive_oe_n(top_drive_oe_n), .bottom_drive(bottom_drive), .fault_o(fault_o),
    .fault_oe_n(fault_oe_n), .irq(irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  mdp_bridge #(.DLY(16)) far_side (.clk(clk), .top_drive_o(top_drive_o),
    .top_drive_oe_n(top_drive_oe_n), .bottom_drive(bottom_drive), .fault_o(fault_o),
    .fault_oe_n(fault_oe_n), .short_cmd(short_cmd), .enable_cmd(enable_cmd),
    .discharge(discharge), .top_drive_i(top_drive_i), .fault_i(fault_i),
    .over_current(over_current), .output_enable(output_enable));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Each note is taken off in the cycle where its result stands at the ports.
  always @(posedge clk) begin
    if (rd_seen || pin_req) begin
      note = notes.pop_front();
      seen = note.pin ? {4'h0, fault_o, top_drive_o, on_cnt, irq, top_drive_oe_n, bottom_drive,
                         fault_oe_n} : reg_rdata;
      checks_done++;
      if ((seen & note.msk) !== note.exp) begin
        errors++;
        $display("BAD %s expected %h seen %h", note.pin ? "pins" : "rdata", note.exp,
                 seen & note.msk);
      end
    end
    rd_seen <= reg_rd;
    on_cnt <= pin_req ? 16'h0000 : on_cnt + {15'h0000, |bottom_drive};
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic expect_pins(input logic [7:0] v);
    notes.push_back('{{24'h0, v}, 32'h0F00_00FF, 1'b1});
    pin_req <= 1'b1;
    @(posedge clk);
    pin_req <= 1'b0;
  endtask

  // The count covers the clock edges with a bottom drive on since the previous pin check.
  task automatic expect_on(input int n);
    notes.push_back('{n << 8, 32'h0FFF_FF00, 1'b1});
    pin_req <= 1'b1;
    @(posedge clk);
    pin_req <= 1'b0;
  endtask

  // speed code duty.
  // Code k crosses the ramp k steps after the start; ten and above run the whole cycle.
  task automatic run_duty(input int k);
    ramp_above_cmd <= 1'b0;
    ramp_start <= 1'b1;
    tick((k < 10 ? k : 10) * STEP);
    ramp_above_cmd <= 1'b1;
    ramp_start <= 1'b0;
    tick(SET);
    expect_on((k < 10 ? k : 10) * STEP);
  endtask

  // A read notes its expected data; the strobes stay up until bus_end.
  task automatic reg_op(input logic wr, input logic [mdp_pkg::ADDR_W-1:0] a,
                        input logic [31:0] d, input logic [31:0] m);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    if (!wr) notes.push_back('{d, m, 1'b0});
    @(posedge clk);
  endtask

  task automatic bus_end();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    tick(2);
  endtask

  // The ramp discharges and the comparator drops before the new cycle starts.
  task automatic run_cycle();
    ramp_start <= 1'b0;
    ramp_above_cmd <= 1'b0;
    tick(4);
    ramp_start <= 1'b1;
    tick(SET);
  endtask

  initial begin
    {sys_rst, enable_cmd, sensor_valid, discharge} = 4'hF;
    {ramp_start, ramp_above_cmd, thermal_shdn, brake, short_cmd, reg_wr, reg_rd} = 7'h00;
    {rd_seen, pin_req, uv_trip, uv_release, reg_addr, reg_wdata} = '0;
    top_cmd = 3'h1;
    bottom_cmd = 3'h2;
    tick(5);
    expect_pins(8'h70);
    sys_rst <= 1'b0;
    tick(SET);
    expect_pins(8'h70);
    uv_release <= 3'h7;
    run_cycle();
    expect_pins(8'h65);
    ramp_above_cmd <= 1'b1;
    tick(SET);
    expect_pins(8'h61);
    ramp_above_cmd <= 1'b0;
    tick(SET);
    expect_pins(8'h61);
    for (int i = 0; i < 6; i++) begin
      p = $unsigned($random(seed)) % 3;
      q = (p + 1 + $unsigned($random(seed)) % 2) % 3;
      top_cmd <= 3'h1 << p;
      bottom_cmd <= 3'h1 << q;
      run_cycle();
      expect_pins({1'b0, ~(3'h1 << p), 3'h1 << q, 1'b1});
    end
    top_cmd <= 3'h1;
    bottom_cmd <= 3'h2;
    ramp_above_cmd <= 1'b1;
    ramp_start <= 1'b0;
    tick(SET);
    expect_pins(8'h61);
    for (int i = 0; i < 4; i++) begin
      run_duty(1 + $unsigned($random(seed)) % 15);
    end
    run_duty(12);
    run_cycle();
    short_cmd <= 1'b1;
    tick(SET + 4);
    expect_pins(8'h71);
    short_cmd <= 1'b0;
    tick(SET);
    expect_pins(8'h71);
    reg_op(1'b0, mdp_pkg::REG_OCCNT, 32'h1, 32'h0000_FFFF);
    bus_end();
    for (int i = 0; i < 7; i++) begin
      {brake, sensor_valid, enable_cmd, thermal_shdn} <= modes[i][11:8];
      run_cycle();
      expect_pins(modes[i][7:0]);
    end
    thermal_shdn <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      uv_trip[k] <= 1'b1;
      uv_release[k] <= 1'b0;
      tick(SET);
      expect_pins(8'h70);
      uv_trip[k] <= 1'b0;
      tick(SET);
      expect_pins(8'h70);
      uv_release[k] <= 1'b1;
      tick(SET);
      expect_pins(8'h7F);
    end
    short_cmd <= 1'b1;
    tick(SET);
    expect_pins(8'h7E);
    discharge <= 1'b0;
    tick(40);
    short_cmd <= 1'b0;
    tick(SET);
    expect_pins(8'h7E);
    discharge <= 1'b1;
    tick(SET);
    expect_pins(8'h7F);
    brake <= 1'b0;
    run_cycle();
    reg_op(1'b0, mdp_pkg::REG_CTRL, 32'h1, 32'hFFFF_FFFF);
    reg_op(1'b1, 8'h14, 32'hFFFF_FFFF, 32'h0);
    reg_op(1'b0, 8'h14, 32'h0, 32'hFFFF_FFFF);
    reg_op(1'b1, mdp_pkg::REG_MASK, 32'h1 << mdp_pkg::EV_OC, 32'h0);
    reg_op(1'b0, mdp_pkg::REG_MASK, 32'h1 << mdp_pkg::EV_OC, 32'hFFFF_FFFF);
    reg_op(1'b1, mdp_pkg::REG_CTRL, 32'h0, 32'h0);
    bus_end();
    tick(SET);
    expect_pins(8'hF0);
    reg_op(1'b1, mdp_pkg::REG_CTRL, 32'h1, 32'h0);
    bus_end();
    run_cycle();
    expect_pins(8'hE5);
    reg_op(1'b0, mdp_pkg::REG_STATE, 32'h0000_0E03, 32'hFFFF_FFFF);
    reg_op(1'b0, mdp_pkg::REG_STAT, 32'h1F, 32'h1F);
    bus_end();
    short_cmd <= 1'b1;
    tick(SET + 4);
    short_cmd <= 1'b0;
    tick(SET);
    expect_pins(8'hF1);
    reg_op(1'b0, mdp_pkg::REG_STAT, 32'h1 << mdp_pkg::EV_OC, 32'h0000_001F);
    reg_op(1'b0, mdp_pkg::REG_OCCNT, 32'h3, 32'h0000_FFFF);
    reg_op(1'b1, mdp_pkg::REG_OCCNT, 32'h0, 32'h0);
    reg_op(1'b0, mdp_pkg::REG_OCCNT, 32'h0, 32'h0000_FFFF);
    bus_end();
    tick(SET);
    expect_pins(8'h71);
    tick(2);
    end_of_test();
  end
endmodule
